// ===== rtl/psm_defs.svh
// Purpose: shared constants of the power monitor serial slave
// Assumes: included by its bare name
// Notes:   bit positions index the command byte
`ifndef PSM_DEFS_SVH
`define PSM_DEFS_SVH
`define PSM_ADDR_BASE 3'h4
`define PSM_C_VCONT   0
`define PSM_C_VONCE   1
`define PSM_C_ICONT   2
`define PSM_C_IONCE   3
`define PSM_C_VRANGE  4
`define PSM_C_STATRD  6
`define PSM_C_EXT     7
`define PSM_BIT_LAST  4'h7
`define PSM_BIT_FULL  4'h8
`define PSM_RES_RST   12'h000
`endif

// ===== rtl/psm_pkg.sv
// Purpose: types of the power monitor serial slave
// Assumes: nothing
// Notes:   one struct per clock domain holds all state
package psm_pkg;
    typedef struct packed {
        logic lvl;
        logic drv;
    } psm_strap_t;

    typedef enum logic [4:0] {
        L_IDLE  = 5'h01,
        L_RX    = 5'h02,
        L_ACK   = 5'h04,
        L_TX    = 5'h08,
        L_TXACK = 5'h10
    } psm_lst_t;

    typedef enum logic [3:0] {
        C_IDLE = 4'h1,
        C_REQ  = 4'h2,
        C_WAIT = 4'h4,
        C_PUB  = 4'h8
    } psm_cst_t;

    typedef struct packed {
        logic        rst_s1, rst_s2, en_s1, en_s2;
        logic        scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
        logic        busy_s1, busy_s2, res_s1, res_s2, res_d;
        logic [7:0]  stat_s1, stat_s2;
        logic [3:0]  strap_s1, strap_s2;
        logic        addr_ok;
        logic [6:0]  dev_addr;
        psm_lst_t    st;
        logic [3:0]  cnt;
        logic [7:0]  shreg;
        logic        first, is_read, ext_pend, status_rd, have_v, have_i;
        logic [1:0]  ext_sel, byte_idx, rd_idx;
        logic [6:0]  cmd_word;
        logic        cmd_tgl, ext_tgl, sda_oe;
        logic [7:0]  ext_data;
        logic [11:0] v_snap, i_snap;
    } psm_link_t;

    typedef struct packed {
        logic        cmd_s1, cmd_s2, cmd_d, ext_s1, ext_s2, ext_d;
        psm_cst_t    st;
        logic        cont_v, cont_i, once_v, once_i, busy, vrange, chan_i;
        logic        conv_start, ext_wr, res_tgl;
        logic [1:0]  ext_sel;
        logic [7:0]  ext_data;
        logic [11:0] v_res, i_res, v_out, i_out;
    } psm_core_t;
endpackage

// ===== rtl/psm_i2c_slave.sv
// Purpose: two-wire slave port of a hot swap power monitor
// Assumes: straps sensed as level plus strong-drive per pin
// Notes:   bus logic on link_clk, converter control on core_clk
`timescale 1ns/10ps
`include "psm_defs.svh"
`default_nettype none
module psm_i2c_slave (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             clk_en,
    input  wire logic             link_clk,
    input  wire logic             scl_in,
    input  wire logic             sda_in,
    output logic                  sda_out,
    output logic                  sda_oe,
    input  wire psm_pkg::psm_strap_t addr_strap_high,
    input  wire psm_pkg::psm_strap_t addr_strap_low,
    output logic                  conv_start,
    output logic                  conv_chan_i,
    output logic                  conv_vrange,
    input  wire logic             adc_done,
    input  wire logic [11:0]      adc_data,
    input  wire logic [7:0]       status_in,
    output logic                  ext_wr,
    output logic [1:0]            ext_sel,
    output logic [7:0]            ext_data,
    output logic                  addr_valid,
    output logic                  conv_busy
);
    import psm_pkg::*;

    psm_link_t l_ff, nxt_l;
    psm_core_t c_ff, nxt_c;

    // four-state strap decode: gnd, resistor, float, high
    function automatic logic [1:0] strap_code(input logic drv, input logic lvl);
        return {lvl, ~(drv ^ lvl)};
    endfunction

    // read byte order: V hi, I hi, packed lows; single channel pads low nibble
    function automatic logic [7:0] tx_byte(input psm_link_t s, input logic [1:0] idx);
        logic [7:0]  b;
        logic [11:0] x;
        b = 8'h00;
        x = s.have_v ? s.v_snap : s.i_snap;
        if (s.status_rd) begin
            b = s.stat_s2;
        end else if (s.have_v && s.have_i) begin
            case (idx)
                2'h0:    b = s.v_snap[11:4];
                2'h1:    b = s.i_snap[11:4];
                2'h2:    b = {s.v_snap[3:0], s.i_snap[3:0]};
                default: b = 8'h00;
            endcase
        end else if (s.have_v || s.have_i) begin
            case (idx)
                2'h0:    b = x[11:4];
                2'h1:    b = {x[3:0], 4'h0};
                default: b = 8'h00;
            endcase
        end
        return b;
    endfunction

    // link domain
    logic scl_rise, scl_fall, bus_start, bus_stop, res_ev;
    logic [7:0] tb;

    always_comb begin
        nxt_l = l_ff;
        nxt_l.rst_s1   = rst;
        nxt_l.rst_s2   = l_ff.rst_s1;
        nxt_l.en_s1    = clk_en;
        nxt_l.en_s2    = l_ff.en_s1;
        nxt_l.scl_s1   = scl_in;
        nxt_l.scl_s2   = l_ff.scl_s1;
        nxt_l.sda_s1   = sda_in;
        nxt_l.sda_s2   = l_ff.sda_s1;
        nxt_l.busy_s1  = c_ff.busy;
        nxt_l.busy_s2  = l_ff.busy_s1;
        nxt_l.res_s1   = c_ff.res_tgl;
        nxt_l.res_s2   = l_ff.res_s1;
        nxt_l.stat_s1  = status_in;
        nxt_l.stat_s2  = l_ff.stat_s1;
        nxt_l.strap_s1 = {addr_strap_high, addr_strap_low};
        nxt_l.strap_s2 = l_ff.strap_s1;
        scl_rise  = l_ff.scl_s2 & ~l_ff.scl_d;
        scl_fall  = ~l_ff.scl_s2 & l_ff.scl_d;
        bus_start = l_ff.scl_s2 & l_ff.scl_d & l_ff.sda_d & ~l_ff.sda_s2;
        bus_stop  = l_ff.scl_s2 & l_ff.scl_d & ~l_ff.sda_d & l_ff.sda_s2;
        res_ev    = l_ff.res_s2 ^ l_ff.res_d;
        tb        = 8'h00;
        if (l_ff.en_s2) begin
            nxt_l.scl_d = l_ff.scl_s2;
            nxt_l.sda_d = l_ff.sda_s2;
            nxt_l.res_d = l_ff.res_s2;
            if (res_ev) begin
                nxt_l.v_snap = c_ff.v_out;
                nxt_l.i_snap = c_ff.i_out;
            end
            if (!l_ff.addr_ok) begin
                nxt_l.addr_ok  = 1'b1;
                nxt_l.dev_addr = {`PSM_ADDR_BASE,
                                  strap_code(l_ff.strap_s2[2], l_ff.strap_s2[3]),
                                  strap_code(l_ff.strap_s2[0], l_ff.strap_s2[1])};
            end
            case (l_ff.st)
                L_RX: begin
                    if (scl_rise) begin
                        nxt_l.shreg = {l_ff.shreg[6:0], l_ff.sda_s2};
                        nxt_l.cnt   = l_ff.cnt + 4'h1;
                    end else if (scl_fall && l_ff.cnt == `PSM_BIT_FULL) begin
                        nxt_l.cnt = 4'h0;
                        if (l_ff.first) begin
                            // a busy single shot refuses the read at address time
                            if (l_ff.shreg[7:1] == l_ff.dev_addr &&
                                !(l_ff.shreg[0] && l_ff.busy_s2)) begin
                                nxt_l.st       = L_ACK;
                                nxt_l.sda_oe   = 1'b1;
                                nxt_l.is_read  = l_ff.shreg[0];
                                nxt_l.first    = 1'b0;
                                nxt_l.byte_idx = 2'h0;
                                nxt_l.rd_idx   = 2'h0;
                                nxt_l.ext_pend = 1'b0;
                            end else begin
                                nxt_l.st = L_IDLE;
                            end
                        end else begin
                            nxt_l.st     = L_ACK;
                            nxt_l.sda_oe = 1'b1;
                            if (l_ff.byte_idx == 2'h0) begin
                                if (l_ff.shreg[`PSM_C_EXT]) begin
                                    nxt_l.ext_pend = (l_ff.shreg[1:0] != 2'h0);
                                    nxt_l.ext_sel  = l_ff.shreg[1:0];
                                end else begin
                                    nxt_l.cmd_word  = l_ff.shreg[6:0];
                                    nxt_l.cmd_tgl   = ~l_ff.cmd_tgl;
                                    nxt_l.status_rd = l_ff.shreg[`PSM_C_STATRD];
                                    nxt_l.have_v    = l_ff.shreg[`PSM_C_VCONT] |
                                                      l_ff.shreg[`PSM_C_VONCE];
                                    nxt_l.have_i    = l_ff.shreg[`PSM_C_ICONT] |
                                                      l_ff.shreg[`PSM_C_IONCE];
                                end
                                nxt_l.byte_idx = 2'h1;
                            end else if (l_ff.ext_pend) begin
                                nxt_l.ext_data = l_ff.shreg;
                                nxt_l.ext_tgl  = ~l_ff.ext_tgl;
                                nxt_l.ext_pend = 1'b0;
                            end
                        end
                    end
                end
                L_ACK: begin
                    if (scl_fall) begin
                        nxt_l.cnt = 4'h0;
                        if (l_ff.is_read) begin
                            tb           = tx_byte(l_ff, l_ff.rd_idx);
                            nxt_l.shreg  = tb;
                            nxt_l.sda_oe = ~tb[7];
                            nxt_l.st     = L_TX;
                        end else begin
                            nxt_l.sda_oe = 1'b0;
                            nxt_l.st     = L_RX;
                        end
                    end
                end
                L_TX: begin
                    if (scl_fall) begin
                        if (l_ff.cnt == `PSM_BIT_LAST) begin
                            nxt_l.sda_oe = 1'b0;
                            nxt_l.st     = L_TXACK;
                        end else begin
                            nxt_l.shreg  = {l_ff.shreg[6:0], 1'b0};
                            nxt_l.sda_oe = ~l_ff.shreg[6];
                            nxt_l.cnt    = l_ff.cnt + 4'h1;
                        end
                    end
                end
                L_TXACK: begin
                    if (scl_rise && l_ff.sda_s2) begin
                        nxt_l.st = L_IDLE;
                    end else if (scl_fall) begin
                        tb           = tx_byte(l_ff, l_ff.rd_idx + 2'h1);
                        nxt_l.rd_idx = l_ff.rd_idx + 2'h1;
                        nxt_l.shreg  = tb;
                        nxt_l.sda_oe = ~tb[7];
                        nxt_l.cnt    = 4'h0;
                        nxt_l.st     = L_TX;
                    end
                end
                default: begin // idle lands here too: released, waiting for a start
                    nxt_l.st     = L_IDLE;
                    nxt_l.sda_oe = 1'b0;
                end
            endcase
            // start or stop abandons whatever was in flight
            if (bus_stop) begin
                nxt_l.st     = L_IDLE;
                nxt_l.sda_oe = 1'b0;
            end else if (bus_start && l_ff.addr_ok) begin
                nxt_l.st     = L_RX;
                nxt_l.cnt    = 4'h0;
                nxt_l.first  = 1'b1;
                nxt_l.sda_oe = 1'b0;
            end
        end
        if (l_ff.rst_s2) begin
            nxt_l          = '0;
            nxt_l.st       = L_IDLE;
            nxt_l.rst_s1   = rst;
            nxt_l.rst_s2   = l_ff.rst_s1;
            nxt_l.scl_d    = 1'b1;
            nxt_l.sda_d    = 1'b1;
            nxt_l.strap_s1 = {addr_strap_high, addr_strap_low};
            nxt_l.strap_s2 = l_ff.strap_s1;
        end
    end

    always_ff @(posedge link_clk) begin
        l_ff <= nxt_l;
    end

    // core domain
    logic cmd_ev, do_v, do_i;

    always_comb begin
        nxt_c = c_ff;
        nxt_c.cmd_s1     = l_ff.cmd_tgl;
        nxt_c.cmd_s2     = c_ff.cmd_s1;
        nxt_c.cmd_d      = c_ff.cmd_s2;
        nxt_c.ext_s1     = l_ff.ext_tgl;
        nxt_c.ext_s2     = c_ff.ext_s1;
        nxt_c.ext_d      = c_ff.ext_s2;
        nxt_c.conv_start = 1'b0;
        cmd_ev = c_ff.cmd_s2 ^ c_ff.cmd_d;
        do_v   = c_ff.once_v | c_ff.cont_v;
        do_i   = c_ff.once_i | c_ff.cont_i;
        nxt_c.ext_wr = c_ff.ext_s2 ^ c_ff.ext_d;
        if (nxt_c.ext_wr) begin
            nxt_c.ext_sel  = l_ff.ext_sel;
            nxt_c.ext_data = l_ff.ext_data;
        end
        case (c_ff.st)
            C_IDLE: begin
                if (do_v || do_i) begin
                    nxt_c.chan_i = ~do_v;
                    nxt_c.st     = C_REQ;
                end
            end
            C_REQ: begin
                nxt_c.conv_start = 1'b1;
                nxt_c.st         = C_WAIT;
            end
            C_WAIT: begin
                if (adc_done) begin
                    if (c_ff.chan_i) begin
                        nxt_c.i_res = adc_data;
                        nxt_c.st    = C_PUB;
                    end else begin
                        nxt_c.v_res = adc_data;
                        // one converter, so current follows voltage
                        if (do_i) begin
                            nxt_c.chan_i = 1'b1;
                            nxt_c.st     = C_REQ;
                        end else begin
                            nxt_c.st = C_PUB;
                        end
                    end
                end
            end
            C_PUB: begin
                nxt_c.v_out   = c_ff.v_res;
                nxt_c.i_out   = c_ff.i_res;
                nxt_c.res_tgl = ~c_ff.res_tgl;
                nxt_c.once_v  = 1'b0;
                nxt_c.once_i  = 1'b0;
                nxt_c.st      = C_IDLE;
            end
            default: nxt_c.st = C_IDLE;
        endcase
        // a command landing with the self-clear keeps its new request
        if (cmd_ev) begin
            nxt_c.cont_v = l_ff.cmd_word[`PSM_C_VCONT];
            nxt_c.once_v = l_ff.cmd_word[`PSM_C_VONCE];
            nxt_c.cont_i = l_ff.cmd_word[`PSM_C_ICONT];
            nxt_c.once_i = l_ff.cmd_word[`PSM_C_IONCE];
            nxt_c.vrange = l_ff.cmd_word[`PSM_C_VRANGE];
        end
        nxt_c.busy = nxt_c.once_v | nxt_c.once_i;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            c_ff       <= '0;
            c_ff.st    <= C_IDLE;
            c_ff.v_res <= `PSM_RES_RST;
            c_ff.i_res <= `PSM_RES_RST;
        end else if (clk_en) begin
            c_ff <= nxt_c;
        end
    end

    assign sda_out     = 1'b0;
    assign sda_oe      = l_ff.sda_oe;
    assign addr_valid  = l_ff.addr_ok;
    assign conv_start  = c_ff.conv_start;
    assign conv_chan_i = c_ff.chan_i;
    assign conv_vrange = c_ff.vrange;
    assign ext_wr      = c_ff.ext_wr;
    assign ext_sel     = c_ff.ext_sel;
    assign ext_data    = c_ff.ext_data;
    assign conv_busy   = c_ff.busy;
endmodule
`default_nettype wire

// ===== tb/psm_i2c_master.sv
// Purpose: behavioural two-wire bus master facing the slave
// Assumes: sda has a pull-up; the master drives scl itself
// Notes:   half period 1250 ns is the 400 kHz fast-mode rate
`timescale 1ns/10ps
`default_nettype none
module psm_i2c_master #(
    parameter int HALF_NS = 1250
) (
    output logic      scl,
    output logic      sda_low,
    input  wire logic sda_line
);
    initial begin
        scl     = 1'b1;
        sda_low = 1'b0;
    end
    // serves as repeated start too: sda released while scl is low
    task automatic bus_start();
        sda_low = 1'b0;
        #(HALF_NS / 2);
        scl = 1'b1;
        #(HALF_NS);
        sda_low = 1'b1;
        #(HALF_NS);
        scl = 1'b0;
        #(HALF_NS / 2);
    endtask
    task automatic bus_stop();
        sda_low = 1'b1;
        #(HALF_NS / 2);
        scl = 1'b1;
        #(HALF_NS);
        sda_low = 1'b0;
        #(HALF_NS);
    endtask
    // sda moves a quarter period after scl falls, after the slave answer
    task automatic bit_io(input logic tx, output logic rx);
        sda_low = !tx;
        #(HALF_NS / 2);
        scl = 1'b1;
        #(HALF_NS / 2);
        rx = sda_line;
        #(HALF_NS / 2);
        scl = 1'b0;
        #(HALF_NS / 2);
    endtask
    task automatic xfer(input logic [7:0] tx, input logic ack_tx, output logic [7:0] rx, output logic ack_rx);
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(ack_tx, ack_rx);
    endtask
endmodule
`default_nettype wire

// ===== tb/psm_i2c_slave_assertions.sv
// Purpose: port checks of the power monitor serial slave
// Assumes: clk_en held high
// Notes:   link checks on link_clk, converter checks on core_clk
`timescale 1ns/10ps
`default_nettype none
module psm_i2c_slave_assertions (
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic       link_clk,
    input wire logic       scl_in,
    input wire logic       sda_out,
    input wire logic       sda_oe,
    input wire logic       conv_start,
    input wire logic       conv_chan_i,
    input wire logic       adc_done,
    input wire logic       ext_wr,
    input wire logic [1:0] ext_sel,
    input wire logic       addr_valid,
    input wire logic       conv_busy
);
    sequence s_start_end;
        ##1 !conv_start;
    endsequence
    sequence s_ext_end;
        ext_sel != 2'h0 ##1 !ext_wr;
    endsequence
    // sync delay: sda may only move three or four link edges into scl low
    sequence s_just_fell;
        !scl_in && ($past(scl_in, 3) || $past(scl_in, 4));
    endsequence
    a_reset_quiet: assert property (@(posedge core_clk) rst && $past(rst) |-> !conv_start && !ext_wr && !conv_busy)
        else $error("outputs active in reset");
    a_start_pulse: assert property (@(posedge core_clk) disable iff (rst) conv_start |-> s_start_end)
        else $error("conversion start longer than one cycle");
    a_ext_pulse: assert property (@(posedge core_clk) disable iff (rst) ext_wr |-> s_ext_end)
        else $error("bad extended write pulse");
    a_chan_hold: assert property (@(posedge core_clk) disable iff (rst) $changed(conv_chan_i) |=> conv_start)
        else $error("channel moved during conversion");
    a_busy_wait: assert property (@(posedge core_clk) disable iff (rst)
        $fell(conv_busy) |-> $past(adc_done) || $past(adc_done, 2) || $past(adc_done, 3))
        else $error("busy cleared without conversion done");
    a_out_low: assert property (@(posedge link_clk) disable iff (rst) sda_out == 1'b0)
        else $error("sda output not low");
    a_oe_timed: assert property (@(posedge link_clk) disable iff (rst) $changed(sda_oe) |-> s_just_fell)
        else $error("sda drive moved outside scl low window");
    a_idle_quiet: assert property (@(posedge link_clk) disable iff (rst) !addr_valid |-> !sda_oe)
        else $error("sda driven before address latched");
    a_valid_holds: assert property (@(posedge link_clk) disable iff (rst) addr_valid |=> addr_valid)
        else $error("address valid dropped");
endmodule
bind psm_i2c_slave psm_i2c_slave_assertions psm_i2c_slave_assertions_i (
    .core_clk(core_clk), .rst(rst), .link_clk(link_clk), .scl_in(scl_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .conv_start(conv_start), .conv_chan_i(conv_chan_i), .adc_done(adc_done),
    .ext_wr(ext_wr), .ext_sel(ext_sel), .addr_valid(addr_valid), .conv_busy(conv_busy)
);
`default_nettype wire

// ===== tb/psm_i2c_slave_tb_top.sv
// Purpose: self-checking bench of the power monitor serial slave
// Assumes: converter modelled here, results fixed per channel
// Notes:   reset held six link cycles so both domains see it
`timescale 1ns/10ps
`default_nettype none
module psm_i2c_slave_tb_top;
    import psm_pkg::*;
    logic        core_clk, link_clk, rst, clk_en, scl, sda_low, sda_line, sda_out, sda_oe;
    logic        conv_start, conv_chan_i, conv_vrange, adc_done, ext_wr, addr_valid, conv_busy;
    logic [11:0] adc_data;
    logic [7:0]  status_in, ext_data;
    logic [1:0]  ext_sel;
    logic [9:0]  ext_seen;
    logic [6:0]  dev;
    psm_strap_t  addr_strap_high, addr_strap_low;
    int          n_errors, num_checks, adc_cnt, adc_delay;
    // rows: strap codes high then low, address they should give
    localparam logic [10:0] ROWS [4] = '{{4'h1, 7'h41}, {4'h6, 7'h46}, {4'hB, 7'h4B}, {4'hC, 7'h4C}};
    assign sda_line = !(sda_low || sda_oe);
    psm_i2c_master psm_i2c_master_i (.scl(scl), .sda_low(sda_low), .sda_line(sda_line));
    psm_i2c_slave psm_i2c_slave_i (
        .core_clk(core_clk), .rst(rst), .clk_en(clk_en), .link_clk(link_clk), .scl_in(scl),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_high(addr_strap_high),
        .addr_strap_low(addr_strap_low), .conv_start(conv_start), .conv_chan_i(conv_chan_i),
        .conv_vrange(conv_vrange), .adc_done(adc_done), .adc_data(adc_data), .status_in(status_in),
        .ext_wr(ext_wr), .ext_sel(ext_sel), .ext_data(ext_data), .addr_valid(addr_valid), .conv_busy(conv_busy)
    );
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        link_clk = 1'b0;
        #3.1;
        forever #62.5 link_clk = ~link_clk;
    end
    // converter answers after adc_delay cycles; voltage 123, current abc
    always @(posedge core_clk) begin
        adc_done <= 1'b0;
        if (ext_wr === 1'b1) ext_seen <= {ext_sel, ext_data};
        if (conv_start === 1'b1) adc_cnt <= adc_delay;
        else if (adc_cnt == 1) begin
            adc_done <= 1'b1;
            adc_data <= conv_chan_i ? 12'hABC : 12'h123;
            adc_cnt  <= 0;
        end else if (adc_cnt > 1) adc_cnt <= adc_cnt - 1;
    end
    function automatic psm_strap_t strap(input logic [1:0] c);
        return '{lvl: c[1], drv: ~(c[1] ^ c[0])};
    endfunction
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic do_reset();
        int i;
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (6) @(posedge link_clk);
        check("reset outputs", 16'({conv_start, ext_wr, conv_busy, addr_valid, sda_oe}), 16'h0);
        @(posedge core_clk);
        rst <= 1'b0;
        for (i = 0; i < 100 && addr_valid !== 1'b1; i++) @(posedge core_clk);
        check("address valid", 16'(addr_valid), 16'h1);
        repeat (4) @(posedge link_clk);
    endtask
    // ack_exp: slave should acknowledge; sp: end with stop, else a repeated start follows
    task automatic wr(input logic [7:0] b0, input logic [7:0] b1, input int n, input logic ack_exp, input logic sp);
        logic [7:0] rx;
        logic       k;
        psm_i2c_master_i.bus_start();
        psm_i2c_master_i.xfer({dev, 1'b0}, 1'b1, rx, k);
        check("write address ack", 16'(k), 16'(!ack_exp));
        if (n > 0) psm_i2c_master_i.xfer(b0, 1'b1, rx, k);
        if (n > 0) check("command ack", 16'(k), 16'h0);
        if (n > 1) psm_i2c_master_i.xfer(b1, 1'b1, rx, k);
        if (n > 1) check("data ack", 16'(k), 16'h0);
        if (sp) psm_i2c_master_i.bus_stop();
    endtask
    task automatic rd(input int n, input logic [23:0] exp, input logic ack_exp);
        logic [7:0] rx;
        logic       k;
        psm_i2c_master_i.bus_start();
        psm_i2c_master_i.xfer({dev, 1'b1}, 1'b1, rx, k);
        check("read address ack", 16'(k), 16'(!ack_exp));
        for (int i = 0; i < n && ack_exp; i++) begin
            psm_i2c_master_i.xfer(8'hFF, i == n - 1, rx, k);
            check("read byte", 16'(rx), 16'(exp[23 - 8 * i -: 8]));
        end
        psm_i2c_master_i.bus_stop();
    endtask
    initial begin
        int i;
        rst = 1'b1;
        clk_en = 1'b1;
        adc_done = 1'b0;
        adc_data = 12'h000;
        status_in = 8'hA5;
        adc_cnt = 0;
        adc_delay = 20;
        ext_seen = 10'h000;
        n_errors = 0;
        num_checks = 0;
        addr_strap_high = strap(2'h0);
        addr_strap_low = strap(2'h0);
        for (int r = 0; r < 4; r++) begin
            @(posedge core_clk);
            addr_strap_high <= strap(ROWS[r][10:9]);
            addr_strap_low <= strap(ROWS[r][8:7]);
            dev = ROWS[r][6:0];
            do_reset();
            wr(8'h00, 8'h00, 0, 1'b1, 1'b1);
            $display("strap row %0d done", r);
        end
        dev = dev ^ 7'h01;
        wr(8'h00, 8'h00, 0, 1'b0, 1'b1);
        dev = dev ^ 7'h01;
        $display("foreign address done");
        adc_delay = 4000;
        wr(8'h02, 8'h00, 1, 1'b1, 1'b1);
        check("busy set", 16'(conv_busy), 16'h1);
        rd(2, 24'h00_0000, 1'b0);
        for (i = 0; i < 5000 && conv_busy !== 1'b0; i++) @(posedge core_clk);
        check("busy cleared", 16'(conv_busy), 16'h0);
        adc_delay = 20;
        rd(2, 24'h12_3000, 1'b1);
        $display("single shot done");
        wr(8'h08, 8'h00, 1, 1'b1, 1'b1);
        repeat (100) @(posedge core_clk);
        rd(2, 24'hAB_C000, 1'b1);
        $display("current single shot done");
        wr(8'h15, 8'h00, 1, 1'b1, 1'b1);
        repeat (300) @(posedge core_clk);
        check("voltage range", 16'(conv_vrange), 16'h1);
        rd(3, 24'h12_AB3C, 1'b1);
        $display("continuous done");
        wr(8'h40, 8'h00, 1, 1'b1, 1'b0);
        rd(2, 24'hA5_A500, 1'b1);
        $display("status read done");
        wr(8'h82, 8'h3C, 2, 1'b1, 1'b1);
        repeat (20) @(posedge core_clk);
        check("extended write", 16'(ext_seen), 16'h023C);
        wr(8'h80, 8'h77, 2, 1'b1, 1'b1);
        repeat (20) @(posedge core_clk);
        check("select zero ignored", 16'(ext_seen), 16'h023C);
        $display("extended write done");
        finish_test();
    end
    initial begin
        repeat (99000) @(posedge core_clk);
        n_errors++;
        finish_test();
    end
endmodule
`default_nettype wire
